/* File: hw/ptm_regs.vh */
// Notes on behaviour
// - every finished conversion is checked against hot and cold; all but the first after wake also against baseline
// - first result after wake rises becomes baseline, no change flag
// - change at or beyond threshold sets change flag and moves baseline
// - smaller change leaves baseline and change flag alone
// - change threshold is a two-bit config field, reset selects two degrees
// - reading at or below cold limit sets cold flag and pulls pin low
// - reading between the limits sets neither hot nor cold flag
// - reading at or above hot limit sets hot flag and pulls pin low
// - change unmask resets clear; while clear change flag leaves pin alone
// - unmask bits gate only the pin, flags always set
// - idle bit reads 0 during conversion; end flag set when it finishes
// - result is 8-bit signed degrees from 10-bit code, clamped -10..85
// - reading a flag register clears it; lasting condition sets again
`ifndef PTM_REGS_VH
`define PTM_REGS_VH

// register offsets
`define PTM_ADDR_READING   8'h00
`define PTM_ADDR_UNMASK1   8'h05
`define PTM_ADDR_UNMASK2   8'h06
`define PTM_ADDR_GROUP1    8'h07
`define PTM_ADDR_GROUP2    8'h08
`define PTM_ADDR_CONFIG    8'h0d
`define PTM_ADDR_LIMITS    8'h0e

// field positions
`define PTM_BIT_CHANGE     7
`define PTM_BIT_HOT        4
`define PTM_BIT_COLD       3
`define PTM_BIT_EOC        0
`define PTM_BIT_TRIGGER    7
`define PTM_BIT_IDLE       5

// reset values
`define PTM_RST_UNMASK1    8'h18
`define PTM_RST_UNMASK2    8'h01
`define PTM_RST_THRESH     2'h1
`define PTM_RST_LIMITS     8'h87

// limit scaling: degrees = base + field
`define PTM_HOT_BASE       8'h2a
`define PTM_COLD_BASE      8'hf9

// clamp bounds of the result
`define PTM_TEMP_MIN       8'hf6
`define PTM_TEMP_MAX       8'h55

// recheck interval of lasting conditions
`define PTM_RECHECK_NS     32000
`define PTM_CLOCK_MHZ      200
`define PTM_RECHECK_CYC    ((`PTM_RECHECK_NS * `PTM_CLOCK_MHZ) / 1000)

`endif

/* File: hw/ptm_code_convert.v */
`timescale 1ns/1ps
`include "ptm_regs.vh"

// 10-bit signed quarter-degree code to clamped 8-bit whole degrees
module ptm_code_convert (
	input  wire [9:0] code,
	output reg  [7:0] degrees
);

	wire signed [7:0] whole;
	wire signed [7:0] lo;
	wire signed [7:0] hi;

	// arithmetic shift floors toward minus infinity, as a thermometer would
	assign whole = code[9:2];
	assign lo    = `PTM_TEMP_MIN;
	assign hi    = `PTM_TEMP_MAX;

	always @* begin
		if (whole < lo)
			degrees = lo;
		else if (whole > hi)
			degrees = hi;
		else
			degrees = whole;
	end

endmodule

/* File: hw/ptm_monitor.v */
`timescale 1ns/1ps
`include "ptm_regs.vh"

module ptm_monitor #(
	parameter RECHECK_CYCLES = `PTM_RECHECK_CYC
) (
	input  wire       clock,
	input  wire       rstn,
	input  wire       wake_pin,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [7:0] reg_rdata,
	output reg        adc_start,
	input  wire       adc_done,
	input  wire [9:0] adc_code,
	output reg        event_pin_n_o,
	output reg        event_pin_n_oe
);

	reg        wake_meta;
	reg        wake_sync;
	reg        wake_last;
	reg        busy;
	reg        base_armed;
	reg [7:0]  temperature_reading;
	reg [7:0]  baseline;
	reg [1:0]  change_threshold;
	reg [7:0]  limits;
	reg        temp_change_unmask;
	reg        hot_unmask;
	reg        cold_unmask;
	reg        eoc_unmask;
	reg        temp_change_flag;
	reg        hot_event;
	reg        cold_event;
	reg        eoc_flag;
	reg        valid_reading;
	reg [12:0] recheck_count;
	reg        recheck_tick;

	wire [7:0] converted;
	wire       wake_rise;
	wire       hot_new;
	wire       cold_new;
	wire       hot_keep;
	wire       cold_keep;
	wire       change_new;
	wire       clear_grp1;
	wire       clear_grp2;
	wire       trigger_write;

	// reset words held as 8-bit constants so single bits can be picked out
	localparam [7:0] RST_UM1 = `PTM_RST_UNMASK1;
	localparam [7:0] RST_UM2 = `PTM_RST_UNMASK2;

	// signed test: value at or above the hot limit
	function at_or_above_hot;
		input [7:0] value;
		input [3:0] field;
		reg   [7:0] lim;
		begin
			lim = `PTM_HOT_BASE + {4'h0, field};
			at_or_above_hot = ($signed(value) >= $signed(lim));
		end
	endfunction

	// signed test: value at or below the cold limit
	function at_or_below_cold;
		input [7:0] value;
		input [3:0] field;
		reg   [7:0] lim;
		begin
			lim = `PTM_COLD_BASE + {4'h0, field};
			at_or_below_cold = ($signed(value) <= $signed(lim));
		end
	endfunction

	// signed distance test against the chosen threshold
	function change_reached;
		input [7:0] value;
		input [7:0] base;
		input [1:0] sel;
		reg   [8:0] diff;
		reg   [8:0] mag;
		reg   [8:0] thr;
		begin
			diff = {value[7], value} - {base[7], base};
			mag  = diff[8] ? (9'h000 - diff) : diff;
			thr  = {7'h00, sel} + 9'h001;
			change_reached = (mag >= thr);
		end
	endfunction

	ptm_code_convert u_convert (
		.code    (adc_code),
		.degrees (converted)
	);

	// wake pin comes from outside, so two flops before use
	always @(posedge clock) begin
		if (!rstn) begin
			wake_meta <= 1'b0;
			wake_sync <= 1'b0;
			wake_last <= 1'b0;
		end else begin
			wake_meta <= wake_pin;
			wake_sync <= wake_meta;
			wake_last <= wake_sync;
		end
	end

	assign wake_rise = wake_sync & ~wake_last;

	// signed ordering in all three checks
	assign hot_new    = adc_done & busy
		& at_or_above_hot(converted, limits[7:4]);
	assign cold_new   = adc_done & busy
		& at_or_below_cold(converted, limits[3:0]);
	assign change_new = adc_done & busy & ~base_armed & ~wake_rise
		& change_reached(converted, baseline, change_threshold);

	// lasting condition is caught again by the periodic recheck
	assign hot_keep  = recheck_tick & valid_reading
		& at_or_above_hot(temperature_reading, limits[7:4]);
	assign cold_keep = recheck_tick & valid_reading
		& at_or_below_cold(temperature_reading, limits[3:0]);

	assign clear_grp1 = reg_read & (reg_addr == `PTM_ADDR_GROUP1);
	assign clear_grp2 = reg_read & (reg_addr == `PTM_ADDR_GROUP2);
	assign trigger_write = reg_write & (reg_addr == `PTM_ADDR_CONFIG)
		& reg_wdata[`PTM_BIT_TRIGGER];

	// recheck timer, free running
	always @(posedge clock) begin
		if (!rstn) begin
			recheck_count <= 13'h0000;
			recheck_tick  <= 1'b0;
		end else if (recheck_count == RECHECK_CYCLES[12:0] - 13'h0001) begin
			recheck_count <= 13'h0000;
			recheck_tick  <= 1'b1;
		end else begin
			recheck_count <= recheck_count + 13'h0001;
			recheck_tick  <= 1'b0;
		end
	end

	// conversion control; a trigger while busy is ignored
	always @(posedge clock) begin
		if (!rstn) begin
			busy      <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			adc_start <= trigger_write & ~busy;
			if (trigger_write & ~busy)
				busy <= 1'b1;
			// idle again once the result lands
			else if (adc_done)
				busy <= 1'b0;
		end
	end

	// result and baseline tracking
	always @(posedge clock) begin
		if (!rstn) begin
			temperature_reading <= 8'h00;
			baseline            <= 8'h00;
			base_armed          <= 1'b1;
			valid_reading       <= 1'b0;
		end else begin
			if (adc_done & busy) begin
				temperature_reading <= converted;
				valid_reading       <= 1'b1;
			end
			if (wake_rise) begin
				base_armed <= 1'b1;
			// first result after wake loads the baseline
			end else if (adc_done & busy & base_armed) begin
				baseline   <= converted;
				base_armed <= 1'b0;
			end else if (change_new) begin
				baseline <= converted;
			end
		end
	end

	// configuration and unmask registers
	always @(posedge clock) begin
		if (!rstn) begin
			// threshold field resets to two degrees
			change_threshold   <= `PTM_RST_THRESH;
			limits             <= `PTM_RST_LIMITS;
			temp_change_unmask <= RST_UM1[`PTM_BIT_CHANGE];
			hot_unmask         <= RST_UM1[`PTM_BIT_HOT];
			cold_unmask        <= RST_UM1[`PTM_BIT_COLD];
			eoc_unmask         <= RST_UM2[`PTM_BIT_EOC];
		end else if (reg_write) begin
			case (reg_addr)
			`PTM_ADDR_CONFIG: begin
				change_threshold <= reg_wdata[1:0];
			end
			`PTM_ADDR_LIMITS: begin
				limits <= reg_wdata;
			end
			`PTM_ADDR_UNMASK1: begin
				temp_change_unmask <= reg_wdata[`PTM_BIT_CHANGE];
				hot_unmask         <= reg_wdata[`PTM_BIT_HOT];
				cold_unmask        <= reg_wdata[`PTM_BIT_COLD];
			end
			`PTM_ADDR_UNMASK2: begin
				eoc_unmask <= reg_wdata[`PTM_BIT_EOC];
			end
			default: begin
				limits <= limits;
			end
			endcase
		end
	end

	// sticky flags; set beats read-clear; wake low clears them all
	// flags set whatever the unmask bits say
	// between the limits neither term is true
	always @(posedge clock) begin
		if (!rstn) begin
			temp_change_flag <= 1'b0;
			hot_event        <= 1'b0;
			cold_event       <= 1'b0;
			eoc_flag         <= 1'b0;
		end else if (!wake_sync) begin
			temp_change_flag <= 1'b0;
			hot_event        <= 1'b0;
			cold_event       <= 1'b0;
			eoc_flag         <= 1'b0;
		end else begin
			if (change_new)
				temp_change_flag <= 1'b1;
			else if (clear_grp1)
				temp_change_flag <= 1'b0;
			if (hot_new | hot_keep)
				hot_event <= 1'b1;
			else if (clear_grp1)
				hot_event <= 1'b0;
			if (cold_new | cold_keep)
				cold_event <= 1'b1;
			else if (clear_grp1)
				cold_event <= 1'b0;
			if (adc_done & busy)
				eoc_flag <= 1'b1;
			else if (clear_grp2)
				eoc_flag <= 1'b0;
		end
	end

	// open-drain pin: only ever drives low
	// change flag gated by its unmask
	always @(posedge clock) begin
		if (!rstn) begin
			event_pin_n_o  <= 1'b0;
			event_pin_n_oe <= 1'b0;
		end else begin
			event_pin_n_o  <= 1'b0;
			event_pin_n_oe <= (temp_change_flag & temp_change_unmask)
				| (hot_event & hot_unmask)
				| (cold_event & cold_unmask)
				| (eoc_flag & eoc_unmask);
		end
	end

	// read data, one cycle after the strobe; unmapped reads return zero
	always @(posedge clock) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			case (reg_addr)
			`PTM_ADDR_READING:
				reg_rdata <= temperature_reading;
			`PTM_ADDR_UNMASK1:
				reg_rdata <= ({7'h00, temp_change_unmask} << `PTM_BIT_CHANGE)
					| ({7'h00, hot_unmask} << `PTM_BIT_HOT)
					| ({7'h00, cold_unmask} << `PTM_BIT_COLD);
			`PTM_ADDR_UNMASK2:
				reg_rdata <= {7'h00, eoc_unmask};
			`PTM_ADDR_GROUP1:
				reg_rdata <= ({7'h00, temp_change_flag} << `PTM_BIT_CHANGE)
					| ({7'h00, hot_event} << `PTM_BIT_HOT)
					| ({7'h00, cold_event} << `PTM_BIT_COLD);
			`PTM_ADDR_GROUP2:
				reg_rdata <= {7'h00, eoc_flag};
			`PTM_ADDR_CONFIG:
				reg_rdata <= ({7'h00, ~busy} << `PTM_BIT_IDLE)
					| {6'h00, change_threshold};
			`PTM_ADDR_LIMITS:
				reg_rdata <= limits;
			default:
				reg_rdata <= 8'h00;
			endcase
		end
	end

endmodule

/* File: bench/ptm_monitor_chk.sv */
`timescale 1ns/1ps
module ptm_monitor_chk (
	input wire       clock,
	input wire       rstn,
	input wire       wake_pin,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_write,
	input wire       reg_read,
	input wire [7:0] reg_rdata,
	input wire       adc_start,
	input wire       adc_done,
	input wire       event_pin_n_o,
	input wire       event_pin_n_oe
);
	reg busy;
	// mirror of a running conversion; a stray done is ignored
	always @(posedge clock) begin
		if (!rstn)
			busy <= 1'b0;
		else if (adc_start)
			busy <= 1'b1;
		else if (adc_done)
			busy <= 1'b0;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// request and completion steps
	sequence trig_s;
		wake_pin && reg_write && reg_addr == 8'h0d && reg_wdata[7]
			&& !busy && !adc_start;
	endsequence
	sequence done_s;
		adc_done && busy && wake_pin;
	endsequence
	sequence rd_s(a);
		reg_read && reg_addr == a;
	endsequence
	start_write_a: assert property (trig_s |=> adc_start)
		else $error("no start after trigger");
	start_pulse_a: assert property (adc_start |=> !adc_start)
		else $error("start longer than a cycle");
	idle_busy_a: assert property ((busy || adc_start) && !adc_done
		##0 rd_s(8'h0d) |=> !reg_rdata[5]) else $error("idle while busy");
	idle_after_a: assert property (done_s ##[1:6] rd_s(8'h0d)
		|=> reg_rdata[5]) else $error("busy after done");
	eoc_flag_a: assert property (done_s ##[1:10] rd_s(8'h08)
		|=> reg_rdata[0]) else $error("end flag missing");
	result_range_a: assert property (done_s ##[1:8] rd_s(8'h00) |=>
		$signed(reg_rdata) >= -10 && $signed(reg_rdata) <= 85)
		else $error("reading out of range");
	rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata))
		else $error("read data moved");
	wake_clear_a: assert property (!wake_pin [*6] |-> !event_pin_n_oe)
		else $error("pin low while asleep");
	pin_low_a: assert property (event_pin_n_oe |-> !event_pin_n_o)
		else $error("pin driven high");
endmodule

/* File: bench/ptm_adc_model.sv */
`timescale 1ns/1ps
module ptm_adc_model (
	input  wire       clock,
	input  wire       adc_start,
	input  wire [9:0] code,
	input  wire [3:0] delay,
	output reg        adc_done,
	output reg  [9:0] adc_code
);
	reg [3:0] cnt = 4'h0;
	reg       run = 1'b0;
	initial adc_done = 1'b0;
	initial adc_code = 10'h2aa;
	// ten-bit code handed over
	// code is only valid in the done cycle, so it toggles otherwise
	always @(posedge clock) begin
		adc_done <= 1'b0;
		adc_code <= ~adc_code;
		if (adc_start) begin
			run <= 1'b1;
			cnt <= delay;
		end else if (run && cnt == 4'h0) begin
			run <= 1'b0;
			adc_done <= 1'b1;
			adc_code <= code;
		end else if (run)
			cnt <= cnt - 4'h1;
	end
endmodule

/* File: bench/panel_temp_threshold_monitor_tb.sv */
`timescale 1ns/1ps
`include "ptm_regs.vh"
module panel_temp_threshold_monitor_tb;
	reg        clock = 1'b0;
	reg        rstn = 1'b0;
	reg        wake_pin = 1'b0;
	reg  [7:0] reg_addr = 8'h00;
	reg  [7:0] reg_wdata = 8'h00;
	reg        reg_write = 1'b0;
	reg        reg_read = 1'b0;
	reg  [9:0] code = 10'h000;
	reg  [3:0] delay = 4'h0;
	reg  [7:0] lf = 8'h19;
	reg  [7:0] got, base, um1, lim, prev, ex;
	reg  [1:0] thr;
	reg        first;
	reg [99:0] tbl = {10'h3fc, 10'h190, 10'h3b0, 10'h004, 10'h000,
		10'h0c4, 10'h0c8, 10'h06c, 10'h068, 10'h064};
	integer    n_mismatch = 0;
	integer    checks_done = 0;
	integer    i;
	wire [7:0] reg_rdata;
	wire [9:0] adc_code;
	wire       adc_start, adc_done, event_pin_n_o, event_pin_n_oe;
	// 200 MHz
	always #2.5 clock = ~clock;
	ptm_monitor #(.RECHECK_CYCLES(16)) ptm_monitor_i (
		.clock(clock), .rstn(rstn), .wake_pin(wake_pin),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .adc_start(adc_start),
		.adc_done(adc_done), .adc_code(adc_code),
		.event_pin_n_o(event_pin_n_o), .event_pin_n_oe(event_pin_n_oe));
	ptm_adc_model ptm_adc_model_i (.clock(clock), .adc_start(adc_start),
		.code(code), .delay(delay), .adc_done(adc_done),
		.adc_code(adc_code));
	// bench helpers: random source, expected reading, bus cycles
	function [7:0] nx(input [7:0] v);
		nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function [7:0] deg(input [9:0] c);
		integer s;
		begin
			s = $signed(c) >>> 2;
			deg = s < -10 ? 8'hf6 : s > 85 ? 8'h55 : s[7:0];
		end
	endfunction
	task ck(input [7:0] g, input [7:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clock) #1;
			reg_addr = a;
			reg_wdata = d;
			reg_write = 1'b1;
			@(posedge clock) #1;
			reg_write = 1'b0;
		end
	endtask
	task rd(input [7:0] a, output [7:0] q);
		begin
			@(posedge clock) #1;
			reg_addr = a;
			reg_read = 1'b1;
			@(posedge clock) #1;
			reg_read = 1'b0;
			q = reg_rdata;
		end
	endtask
	task rc(input [7:0] a, input [7:0] e);
		begin
			rd(a, got);
			ck(got, e);
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", checks_done, n_mismatch);
			if (n_mismatch == 0 && checks_done > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// one conversion; hot or cold bits left from an older reading may reappear
	task conv(input [9:0] c);
		integer k, d, t;
		reg [7:0] e, stk;
		begin
			code = c;
			delay = lf[3:0];
			wr(8'h0d, {6'h20, thr});
			k = 0;
			got = 8'h00;
			while (!got[5] && k < 60) begin
				rd(8'h0d, got);
				k = k + 1;
			end
			if (got[5] !== 1'b1) begin
				n_mismatch = n_mismatch + 1;
				report_and_stop;
			end
			ck(got, {2'h0, 1'b1, 3'h0, thr});
			e = deg(c);
			rc(8'h00, e);
			rc(8'h08, 8'h01);
			d = $signed(e) - $signed(base);
			t = thr + 1;
			ex = 8'h00;
			ex[7] = !first && (d >= t || d <= -t);
			if (first || ex[7])
				base = e;
			first = 1'b0;
			ex[4] = $signed(e) >= $signed(`PTM_HOT_BASE + lim[7:4]);
			ex[3] = $signed(e) <= $signed(`PTM_COLD_BASE + lim[3:0]);
			stk = prev & ~ex;
			@(posedge clock) #1;
			if (stk == 8'h00)
				ck({7'h0, event_pin_n_oe}, {7'h0, |(ex & um1)});
			rd(8'h07, got);
			ck(got | stk, ex | stk);
			prev = ex & 8'h18;
		end
	endtask
	// main sequence
	initial begin
		base = 8'h00;
		prev = 8'h00;
		first = 1'b1;
		thr = 2'h1;
		lim = 8'h87;
		um1 = 8'h18;
		repeat (12) @(posedge clock);
		#1 rstn = 1'b1;
		wake_pin = 1'b1;
		repeat (3) @(posedge clock);
		rc(8'h05, 8'h18);
		rc(8'h06, 8'h01);
		rc(8'h0d, 8'h21);
		rc(8'h0e, 8'h87);
		rc(8'h01, 8'h00);
		$display("test reset values done");
		for (i = 0; i < 10; i = i + 1)
			conv(tbl[i*10 +: 10]);
		$display("test corner readings done");
		for (i = 0; i < 16; i = i + 1) begin
			lf = nx(lf);
			if (i % 4 == 3) begin
				lim = lf;
				thr = lf[1:0];
				prev = 8'h18;
				wr(8'h0e, lim);
				wr(8'h0d, {6'h00, thr});
				rc(8'h0e, lim);
			end
			conv({lf, lf[1:0]});
		end
		$display("test random readings done");
		um1 = 8'h00;
		wr(8'h05, um1);
		wr(8'h06, 8'h00);
		rc(8'h06, 8'h00);
		lim = 8'h87;
		wr(8'h0e, lim);
		prev = 8'h18;
		conv(10'h190);
		repeat (40) @(posedge clock);
		ck({7'h0, event_pin_n_oe}, 8'h00);
		rc(8'h07, 8'h10);
		um1 = 8'h98;
		wr(8'h05, um1);
		rc(8'h05, um1);
		conv(10'h064);
		conv(10'h07c);
		$display("test masking done");
		wake_pin = 1'b0;
		repeat (6) @(posedge clock);
		#1 wake_pin = 1'b1;
		repeat (3) @(posedge clock);
		first = 1'b1;
		conv(10'h3b0);
		conv(10'h000);
		$display("test wake done");
		report_and_stop;
	end
endmodule
bind ptm_monitor ptm_monitor_chk ptm_monitor_chk_i (
	.clock(clock), .rstn(rstn), .wake_pin(wake_pin), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .adc_start(adc_start), .adc_done(adc_done),
	.event_pin_n_o(event_pin_n_o), .event_pin_n_oe(event_pin_n_oe));
